// ==== eam_phase_if.sv ====
// bundle of per-phase samples passed from the top to the phase-b derivation unit
// assumes one clock domain; samples are signed two's complement
`timescale 1ns/1ps
`default_nettype none
interface eam_phase_if;
   import eam_pkg::*;
   logic signed [SAMPLE_W-1:0] va;
   logic signed [SAMPLE_W-1:0] vb;
   logic signed [SAMPLE_W-1:0] vc;
   logic signed [SAMPLE_W-1:0] vb_eff;
   logic [1:0] consel;
   modport src (output va, vb, vc, consel, input vb_eff);
   modport dst (input va, vb, vc, consel, output vb_eff);
endinterface
`default_nettype wire

// ==== eam_pkg.sv ====
// package for the energy accumulation mode select block: register map, fields, reset values
// assumes an apb slave with 32-bit data and word-aligned registers
package eam_pkg;
   localparam int SAMPLE_W = 24;
   localparam logic [11:0] CONFIG_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [11:0] MASK_ADDR = 12'h008;
   localparam logic [11:0] PHASE_B_VOLTAGE_RMS_ADDR = 12'h00C;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam int VAR_MODE_LSB = 2;
   localparam int CONSEL_LSB = 4;
   localparam int REVAP_SEL_BIT = 6;
   localparam int REVRP_SEL_BIT = 7;
   localparam int REVAP_LSB = 6;
   localparam int REVRP_LSB = 10;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   typedef enum logic [1:0] {
      EAM_VAR_SIGNED = 2'h0,
      EAM_VAR_RSVD = 2'h1,
      EAM_VAR_SIGN_GOVERNED = 2'h2,
      EAM_VAR_ABSOLUTE = 2'h3
   } eam_var_mode_e;
   typedef enum logic [1:0] {
      EAM_WYE_3V = 2'h0,
      EAM_DELTA_3W = 2'h1,
      EAM_WYE_2V = 2'h2,
      EAM_DELTA_4W = 2'h3
   } eam_consel_e;
endpackage

// ==== eam_top.sv ====
// accumulation mode select: reactive pulse mode, connection select, reverse power flags
// assumes samples arrive with a one-cycle valid strobe from the dsp on pclk; apb master
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - reactive mode 00: reactive powers feed pulse outputs signed
// - reactive mode 10: pulse reactive sign follows matching active power sign
// - in mode 10, positive active adds reactive as is, negative negates it
// - reactive mode 11: pulse outputs take absolute reactive power
// - reactive energy registers always accumulate signed, mode affects pulses only
// - connection select at config bits 5:4, reset 00, picks energy inputs
// - 00 wye three sensors, 01 delta 3-wire, 10 wye two sensors, 11 delta 4-wire
// - reactive energy uses voltage times quarter-period shifted current
// - in 3-wire delta, phase b rms result holds line a-c rms
// - reverse active flags bits 6..8 from total active power when select clear
// - reverse active flags from fundamental active power when select set
// - reverse reactive flags bits 10..12 from total reactive when select clear
// - reverse reactive flags from fundamental reactive power when select set
// - reverse active select at bit 6, reverse reactive select bit 7, both reset 0
module eam_top
   import eam_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic signed [SAMPLE_W-1:0] va,
   input wire logic signed [SAMPLE_W-1:0] vb,
   input wire logic signed [SAMPLE_W-1:0] vc,
   input wire logic signed [3*SAMPLE_W-1:0] total_active,
   input wire logic signed [3*SAMPLE_W-1:0] fund_active,
   input wire logic signed [3*SAMPLE_W-1:0] total_reactive,
   input wire logic signed [3*SAMPLE_W-1:0] fund_reactive,
   input wire logic [SAMPLE_W-1:0] line_ac_rms,
   output logic signed [6*SAMPLE_W-1:0] reactive_energy_term,
   output logic signed [6*SAMPLE_W-1:0] reactive_pulse_term,
   output logic signed [SAMPLE_W-1:0] phase_b_voltage,
   output logic [SAMPLE_W-1:0] phase_b_voltage_rms,
   output logic [1:0] connection_select,
   output logic irq
);
   logic [7:0] accumulation_mode_config;
   logic [15:0] event_status_low;
   logic [15:0] event_mask;
   logic [5:0] rev_now;
   logic [15:0] rev_set;
   logic apb_wr;
   logic apb_rd;
   eam_phase_if ph ();

   function automatic logic signed [SAMPLE_W-1:0] eam_neg_sat(input logic signed [SAMPLE_W-1:0] x);
      eam_neg_sat = (x == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? {1'b0, {(SAMPLE_W-1){1'b1}}} : -x;
   endfunction

   // map one reactive power to its pulse contribution under the chosen mode
   function automatic logic signed [SAMPLE_W-1:0] eam_pulse(input logic [1:0] mode,
         input logic signed [SAMPLE_W-1:0] q, input logic signed [SAMPLE_W-1:0] p);
      unique case (eam_var_mode_e'(mode))
         EAM_VAR_SIGN_GOVERNED: eam_pulse = p[SAMPLE_W-1] ? eam_neg_sat(q) : q;
         EAM_VAR_ABSOLUTE: eam_pulse = q[SAMPLE_W-1] ? eam_neg_sat(q) : q;
         EAM_VAR_SIGNED, EAM_VAR_RSVD: eam_pulse = q;
      endcase
   endfunction

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;
   assign ph.va = va;
   assign ph.vb = vb;
   assign ph.vc = vc;
   assign ph.consel = accumulation_mode_config[CONSEL_LSB +: 2];

   eam_vb_derive u_vb (
      .pclk(pclk),
      .presetn(presetn),
      .ph(ph)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accumulation_mode_config <= CONFIG_RESET;
         event_mask <= MASK_RESET;
      end else if (apb_wr && paddr == CONFIG_ADDR) begin
         accumulation_mode_config <= pwdata[7:0];
      end else if (apb_wr && paddr == MASK_ADDR) begin
         event_mask <= pwdata[15:0];
      end
   end

   // reverse power detection, source picked per select bit
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         rev_now[i] = accumulation_mode_config[REVAP_SEL_BIT] ?
            fund_active[i*SAMPLE_W + SAMPLE_W-1] : total_active[i*SAMPLE_W + SAMPLE_W-1];
         rev_now[3+i] = accumulation_mode_config[REVRP_SEL_BIT] ?
            fund_reactive[i*SAMPLE_W + SAMPLE_W-1] : total_reactive[i*SAMPLE_W + SAMPLE_W-1];
      end
      rev_set = '0;
      if (sample_valid) begin
         rev_set[REVAP_LSB +: 3] = rev_now[2:0];
         rev_set[REVRP_LSB +: 3] = rev_now[5:3];
      end
   end

   // read clears only the bits it returned, so a flag set during the setup cycle is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_status_low <= STATUS_RESET;
      end else if (apb_rd && paddr == STATUS_ADDR) begin
         event_status_low <= (event_status_low & ~prdata[15:0]) | rev_set;
      end else begin
         event_status_low <= event_status_low | rev_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((event_status_low | rev_set) & event_mask);
      end
   end

   // zero-wait apb: pready high in every access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= '0;
         if (psel && !penable) begin
            unique case (paddr)
               CONFIG_ADDR: prdata <= {24'h000000, accumulation_mode_config};
               STATUS_ADDR: prdata <= {16'h0000, event_status_low};
               MASK_ADDR: prdata <= {16'h0000, event_mask};
               PHASE_B_VOLTAGE_RMS_ADDR: prdata <= 32'(phase_b_voltage_rms);
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // energy terms: registers always see signed reactive, pulses see the mode mapping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reactive_energy_term <= '0;
         reactive_pulse_term <= '0;
      end else if (sample_valid) begin
         for (int i = 0; i < 3; i++) begin
            // reactive inputs are already v times the quarter-period shifted current
            reactive_energy_term[i*SAMPLE_W +: SAMPLE_W] <= total_reactive[i*SAMPLE_W +: SAMPLE_W];
            reactive_energy_term[(3+i)*SAMPLE_W +: SAMPLE_W] <= fund_reactive[i*SAMPLE_W +: SAMPLE_W];
            reactive_pulse_term[i*SAMPLE_W +: SAMPLE_W] <=
               eam_pulse(accumulation_mode_config[VAR_MODE_LSB +: 2],
                  total_reactive[i*SAMPLE_W +: SAMPLE_W], total_active[i*SAMPLE_W +: SAMPLE_W]);
            reactive_pulse_term[(3+i)*SAMPLE_W +: SAMPLE_W] <=
               eam_pulse(accumulation_mode_config[VAR_MODE_LSB +: 2],
                  fund_reactive[i*SAMPLE_W +: SAMPLE_W], fund_active[i*SAMPLE_W +: SAMPLE_W]);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_b_voltage <= '0;
         phase_b_voltage_rms <= '0;
         connection_select <= 2'h0;
      end else begin
         phase_b_voltage <= ph.vb_eff;
         connection_select <= accumulation_mode_config[CONSEL_LSB +: 2];
         if (accumulation_mode_config[CONSEL_LSB +: 2] == EAM_DELTA_3W) begin
            phase_b_voltage_rms <= line_ac_rms;
         end else begin
            phase_b_voltage_rms <= '0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== eam_top_asserts.sv ====
// concurrent checks on the ports of the accumulation mode select block
// assumes apb writes land at the access edge and one pclk domain; bound below
`timescale 1ns/1ps
`default_nettype none
module eam_top_asserts
   import eam_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic sample_valid,
   input wire logic signed [3*SAMPLE_W-1:0] total_active,
   input wire logic signed [3*SAMPLE_W-1:0] total_reactive,
   input wire logic signed [3*SAMPLE_W-1:0] fund_reactive,
   input wire logic [SAMPLE_W-1:0] line_ac_rms,
   input wire logic signed [6*SAMPLE_W-1:0] reactive_energy_term,
   input wire logic signed [6*SAMPLE_W-1:0] reactive_pulse_term,
   input wire logic [SAMPLE_W-1:0] phase_b_voltage_rms,
   input wire logic [1:0] connection_select
);
   // shadow of the config register, kept from the bus traffic alone
   logic [7:0] cfg;
   logic [SAMPLE_W-1:0] qa, qn;
   logic pa;
   assign qa = total_reactive[SAMPLE_W-1:0];
   assign pa = total_active[SAMPLE_W-1];
   // negation saturates, so the most negative code maps to the largest positive
   assign qn = (qa == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? ~qa : -qa;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) cfg <= CONFIG_RESET;
      else if (psel && penable && pready && pwrite && paddr == CONFIG_ADDR) cfg <= pwdata[7:0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_cfg_wr;
      psel && !penable && pwrite && paddr == CONFIG_ADDR ##1 psel && penable && pready;
   endsequence
   property p_consel;
      s_cfg_wr |=> ##1 connection_select == cfg[5:4];
   endproperty
   a_consel: assert property (p_consel) else $error("connection select mismatch");
   property p_cfg_rd;
      psel && penable && pready && !pwrite && paddr == CONFIG_ADDR |-> prdata[7:0] == cfg;
   endproperty
   a_cfg_rd: assert property (p_cfg_rd) else $error("config read mismatch");
   property p_energy;
      sample_valid |=> reactive_energy_term == {$past(fund_reactive), $past(total_reactive)};
   endproperty
   a_energy: assert property (p_energy) else $error("energy term not signed");
   property p_signed;
      sample_valid && !cfg[3] |=> reactive_pulse_term == reactive_energy_term;
   endproperty
   a_signed: assert property (p_signed) else $error("pulse term not signed");
   property p_govern;
      sample_valid && cfg[3:2] == 2'h2 |=> reactive_pulse_term[SAMPLE_W-1:0] == ($past(pa) ? $past(qn) : $past(qa));
   endproperty
   a_govern: assert property (p_govern) else $error("sign governed pulse wrong");
   property p_abs;
      sample_valid && cfg[3:2] == 2'h3 |=> reactive_pulse_term[SAMPLE_W-1:0] == ($past(qa[SAMPLE_W-1]) ? $past(qn) : $past(qa));
   endproperty
   a_abs: assert property (p_abs) else $error("absolute pulse wrong");
   property p_rms_zero;
      connection_select != 2'h1 && $past(connection_select) != 2'h1 |-> phase_b_voltage_rms == '0;
   endproperty
   a_rms_zero: assert property (p_rms_zero) else $error("phase b rms not zero");
   property p_rms_delta;
      connection_select == 2'h1 && $past(connection_select) == 2'h1 && $stable(line_ac_rms) |-> phase_b_voltage_rms == line_ac_rms;
   endproperty
   a_rms_delta: assert property (p_rms_delta) else $error("phase b rms not line rms");
endmodule
bind eam_top eam_top_asserts i_chk (.*);
`default_nettype wire

// ==== eam_vb_derive.sv ====
// derives the phase b voltage used by the energy terms from the connection select
// assumes consel is registered by the instantiating module; va, vb and vc arrive straight from its ports
`timescale 1ns/1ps
`default_nettype none
module eam_vb_derive
   import eam_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   eam_phase_if.dst ph
);
   logic signed [SAMPLE_W:0] next_vb;

   always_comb begin
      unique case (eam_consel_e'(ph.consel))
         EAM_DELTA_3W: next_vb = (SAMPLE_W+1)'(ph.va) - (SAMPLE_W+1)'(ph.vc);
         EAM_WYE_2V: next_vb = -(SAMPLE_W+1)'(ph.va) - (SAMPLE_W+1)'(ph.vc);
         EAM_DELTA_4W: next_vb = -(SAMPLE_W+1)'(ph.va);
         EAM_WYE_3V: next_vb = (SAMPLE_W+1)'(ph.vb);
      endcase
   end

   // saturate to sample width: -va-vc can exceed full scale
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph.vb_eff <= '0;
      end else if (next_vb > (SAMPLE_W+1)'(2**(SAMPLE_W-1)-1)) begin
         ph.vb_eff <= {1'b0, {(SAMPLE_W-1){1'b1}}};
      end else if (next_vb < -(SAMPLE_W+1)'(2**(SAMPLE_W-1))) begin
         ph.vb_eff <= {1'b1, {(SAMPLE_W-1){1'b0}}};
      end else begin
         ph.vb_eff <= next_vb[SAMPLE_W-1:0];
      end
   end
endmodule
`default_nettype wire

// ==== tb_eam_top.sv ====
// self-checking bench for the accumulation mode select block
// assumes zero-wait apb slave and registered outputs as handed over
`timescale 1ns/1ps
`default_nettype none
module tb_eam_top
   import eam_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, irq;
   logic signed [SAMPLE_W-1:0] va = '0, vb = '0, vc = '0, phase_b_voltage;
   logic signed [3*SAMPLE_W-1:0] total_active = '0, fund_active = '0, total_reactive = '0, fund_reactive = '0;
   logic [SAMPLE_W-1:0] line_ac_rms = '0, phase_b_voltage_rms;
   logic signed [6*SAMPLE_W-1:0] reactive_energy_term, reactive_pulse_term;
   logic [1:0] connection_select;
   int n_fail = 0, num_checks = 0, seed = 41487;
   logic [32:0] exp_q[$];
   logic [15:0] st;
   logic [7:0] cfg;
   eam_top i_dut (.*);
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
      num_checks++;
      if ({pslverr, prdata} !== exp_q[0]) begin
         n_fail++;
         $display("BAD read %h exp %h got %h", paddr, exp_q[0], {pslverr, prdata});
      end
      void'(exp_q.pop_front());
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0; penable <= 0;
      // one idle edge so the strobe is never driven twice in a time step
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(0, a, 0);
   endtask
   function automatic logic [3*SAMPLE_W-1:0] rnd();
      return (3*SAMPLE_W)'({$random(seed), $random(seed), $random(seed)});
   endfunction
   function automatic logic [SAMPLE_W-1:0] pexp(input logic [1:0] m, input logic signed [SAMPLE_W-1:0] q,
         input logic signed [SAMPLE_W-1:0] p);
      logic neg;
      neg = (m == 2'h2 && p < 0) || (m == 2'h3 && q < 0);
      if (!neg) return q;
      return (q == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? ~q : -q;
   endfunction
   function automatic logic signed [SAMPLE_W-1:0] vb_exp(input logic [1:0] c);
      longint s;
      case (c)
         2'h0: s = vb;
         2'h1: s = va - vc;
         2'h2: s = -va - vc;
         default: s = -va;
      endcase
      if (s > 2**(SAMPLE_W-1)-1) s = 2**(SAMPLE_W-1)-1;
      if (s < -(2**(SAMPLE_W-1))) s = -(2**(SAMPLE_W-1));
      return s[SAMPLE_W-1:0];
   endfunction
   task automatic samp(input logic [7:0] c);
      logic [3*SAMPLE_W-1:0] ta, fa, tq, fq;
      ta = rnd(); fa = rnd(); tq = rnd(); fq = rnd();
      st = '0;
      for (int p = 0; p < 3; p++) begin
         st[REVAP_LSB+p] = c[REVAP_SEL_BIT] ? fa[SAMPLE_W*p+SAMPLE_W-1] : ta[SAMPLE_W*p+SAMPLE_W-1];
         st[REVRP_LSB+p] = c[REVRP_SEL_BIT] ? fq[SAMPLE_W*p+SAMPLE_W-1] : tq[SAMPLE_W*p+SAMPLE_W-1];
      end
      total_active <= ta; fund_active <= fa; total_reactive <= tq; fund_reactive <= fq;
      va <= SAMPLE_W'($random(seed)); vb <= SAMPLE_W'($random(seed)); vc <= SAMPLE_W'($random(seed));
      line_ac_rms <= SAMPLE_W'($random(seed));
      sample_valid <= 1;
      @(posedge pclk);
      sample_valid <= 0;
      @(posedge pclk);
      #1;
   endtask
   task print_verdict;
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rd(CONFIG_ADDR, 33'(CONFIG_RESET));
      rd(STATUS_ADDR, 33'(STATUS_RESET));
      rd(12'h010, {1'b1, 32'h0});
      apb(1, MASK_ADDR, 32'h1DC0);
      rd(MASK_ADDR, 33'h1DC0);
      // select bits, connection and reactive mode each walk all four codes
      for (int i = 0; i < 16; i++) begin
         cfg = {i[1:0], i[3:2], i[1:0], 2'h0};
         apb(1, CONFIG_ADDR, 32'(cfg));
         rd(CONFIG_ADDR, 33'(cfg));
         samp(cfg);
         chk("irq", 32'(|st), 32'(irq));
         rd(STATUS_ADDR, 33'(st));
         rd(PHASE_B_VOLTAGE_RMS_ADDR, i[3:2] == 2'h1 ? 33'(line_ac_rms) : 33'h0);
         #1;
         chk("irq", 0, 32'(irq));
         chk("phase_b_voltage", 32'(vb_exp(i[3:2])), 32'(phase_b_voltage));
         chk("connection_select", 32'(i[3:2]), 32'(connection_select));
         chk("energy_fund_c", 32'(fund_reactive[3*SAMPLE_W-1 -: SAMPLE_W]), 32'(reactive_energy_term[6*SAMPLE_W-1 -: SAMPLE_W]));
         chk("pulse_fund_c", 32'(pexp(i[1:0], fund_reactive[3*SAMPLE_W-1 -: SAMPLE_W], fund_active[3*SAMPLE_W-1 -: SAMPLE_W])), 32'(reactive_pulse_term[6*SAMPLE_W-1 -: SAMPLE_W]));
      end
      apb(1, MASK_ADDR, 0);
      samp(cfg);
      chk("irq", 0, 32'(irq));
      rd(STATUS_ADDR, 33'(st));
      print_verdict;
   end
endmodule
`default_nettype wire
